/* File: hdl/ebsr_pkg.sv */
// constants for the excitation, bias and system control register slice
`default_nettype none
package ebsr_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] EBSR_ADDR_ROUTE = 8'h07;
  localparam logic [7:0] EBSR_ADDR_BIAS = 8'h08;
  localparam logic [7:0] EBSR_ADDR_SYS = 8'h09;
  // reset values
  localparam logic [7:0] EBSR_RST_ROUTE = 8'hFF;
  localparam logic [7:0] EBSR_RST_BIAS = 8'h00;
  localparam logic [7:0] EBSR_RST_SYS = 8'h10;
  // routing field positions and codes
  localparam int EBSR_RT2_LSB = 4;
  localparam int EBSR_RT1_LSB = 0;
  localparam logic [3:0] EBSR_RT_COM = 4'hC;
  localparam logic [3:0] EBSR_RT_LAST_IN6 = 4'h7;
  localparam logic [3:0] EBSR_RT_LAST_IN12 = 4'hB;
  // bias register bit positions
  localparam int EBSR_BIAS_LVL = 7;
  localparam int EBSR_BIAS_COM = 6;
  // system control field positions
  localparam int EBSR_MONITOR_SELECT_LSB = 5;
  localparam int EBSR_SYS_CAL_LSB = 3;
  localparam int EBSR_SYS_TMO = 2;
  localparam int EBSR_SYS_CRC = 1;
  localparam int EBSR_SYS_STAT = 0;
  // calibration sample counts per code
  localparam logic [4:0] EBSR_CAL_N0 = 5'h01;
  localparam logic [4:0] EBSR_CAL_N1 = 5'h04;
  localparam logic [4:0] EBSR_CAL_N2 = 5'h08;
  localparam logic [4:0] EBSR_CAL_N3 = 5'h10;
  // conversion result word length in bytes, without extras
  localparam logic [2:0] EBSR_RES_BYTES = 3'h3;
endpackage
`default_nettype wire

/* File: hdl/ebsr_regs.sv */
// excitation routing, sensor bias and system control register slice
// Function
// RULE1 - second source route field, bits 7:4, reset Fh
// RULE2 - code 6/7: input 6/7 or reference
// RULE3 - codes 8-11 wide only, C common, else off
// RULE4 - first source route field, bits 3:0, same map
// RULE5 - bit 7 picks midpoint or sum over twelve
// RULE6 - bias generator off when no input connected
// RULE7 - bit 6 connects bias to common input
// RULE8 - bits 5:0 connect bias to inputs 5:0
// RULE9 - bias connect bits act independently
// RULE10 - bias register at 08h, reset 00h
// RULE11 - system control at 09h, reset 10h, fields
// RULE12 - calibration code selects 1, 4, 8, 16 samples
// RULE13 - crc enable appends crc byte over result
// RULE14 - status enable prepends status byte
// RULE15 - timeout enable activates serial timeout
// RULE16 - fields read back last written value
//
// Our own choice: strobed register access.
`default_nettype none
module ebsr_regs
  import ebsr_pkg::*;
#(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // excitation routing, one-hot over 12 inputs, ref pair, common
  output logic [11:0] SRC1_TO_INPUT,
  output logic SRC1_TO_REFP,
  output logic SRC1_TO_REFN,
  output logic SRC1_TO_COMMON,
  output logic [11:0] SRC2_TO_INPUT,
  output logic SRC2_TO_REFP,
  output logic SRC2_TO_REFN,
  output logic SRC2_TO_COMMON,
  // bias voltage controls
  output logic BIAS_GEN_EN,
  output logic BIAS_LEVEL_SEL,
  output logic BIAS_TO_COMMON,
  output logic [5:0] BIAS_TO_INPUT,
  // system control
  output logic [2:0] MONITOR_SELECT,
  output logic [4:0] CAL_SAMPLES,
  output logic TIMEOUT_ENABLE,
  output logic CRC_APPEND,
  output logic STATUS_PREPEND,
  output logic [2:0] RESULT_BYTES
);

  logic [7:0] route_r;
  logic [7:0] bias_r;
  logic [7:0] sys_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // address decode
  wire hit_route = (ADDR == EBSR_ADDR_ROUTE);
  wire hit_bias = (ADDR == EBSR_ADDR_BIAS); // RULE10
  wire hit_sys = (ADDR == EBSR_ADDR_SYS); // RULE11

  // register storage, plain read/write
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      route_r <= EBSR_RST_ROUTE; // RULE1 RULE4
      bias_r <= EBSR_RST_BIAS; // RULE10
      sys_r <= EBSR_RST_SYS; // RULE11
    end else if (WR) begin
      if (hit_route) route_r <= WDATA; // RULE16
      if (hit_bias) bias_r <= WDATA; // RULE16
      if (hit_sys) sys_r <= WDATA; // RULE16
    end
  end

  // read mux, unmapped reads zero
  assign rdata_nxt = hit_route ? route_r :
                     hit_bias ? bias_r :
                     hit_sys ? sys_r : 8'h00; // RULE16

  // read data stand only in the cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= RD ? rdata_nxt : 8'h00;
    end
  end
  assign RDATA = rdata_r;

  // route code decode, one generate block per input serving both sources
  wire [3:0] code1 = route_r[EBSR_RT1_LSB +: 4]; // RULE4
  wire [3:0] code2 = route_r[EBSR_RT2_LSB +: 4]; // RULE1
  wire [3:0] last_in = WIDE_VARIANT ? EBSR_RT_LAST_IN12 : EBSR_RT_LAST_IN6;
  logic [11:0] in1;
  logic [11:0] in2;
  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_in
      localparam logic [3:0] CODE = 4'(g);
      // codes 6, 7 count as inputs only on the wide variant
      wire ok = (CODE <= last_in) && (WIDE_VARIANT || g < 6);
      assign in1[g] = ok && (code1 == CODE); // RULE4 RULE2 RULE3
      assign in2[g] = ok && (code2 == CODE); // RULE1 RULE2 RULE3
    end
  endgenerate
  assign SRC1_TO_INPUT = in1;
  assign SRC2_TO_INPUT = in2;
  // narrow variant sends codes 6 and 7 to the reference pair
  assign SRC1_TO_REFP = !WIDE_VARIANT && (code1 == 4'h6); // RULE2
  assign SRC1_TO_REFN = !WIDE_VARIANT && (code1 == 4'h7); // RULE2
  assign SRC2_TO_REFP = !WIDE_VARIANT && (code2 == 4'h6); // RULE2
  assign SRC2_TO_REFN = !WIDE_VARIANT && (code2 == 4'h7); // RULE2
  assign SRC1_TO_COMMON = (code1 == EBSR_RT_COM); // RULE3
  assign SRC2_TO_COMMON = (code2 == EBSR_RT_COM); // RULE3

  // bias controls, each bit independent
  assign BIAS_LEVEL_SEL = bias_r[EBSR_BIAS_LVL]; // RULE5
  assign BIAS_TO_COMMON = bias_r[EBSR_BIAS_COM]; // RULE7
  assign BIAS_TO_INPUT = bias_r[5:0]; // RULE8 RULE9
  assign BIAS_GEN_EN = |bias_r[EBSR_BIAS_COM:0]; // RULE6

  // system control fields
  wire [1:0] cal_code = sys_r[EBSR_SYS_CAL_LSB +: 2];
  assign MONITOR_SELECT = sys_r[EBSR_MONITOR_SELECT_LSB +: 3]; // RULE11
  assign CAL_SAMPLES = (cal_code == 2'h0) ? EBSR_CAL_N0 :
                       (cal_code == 2'h1) ? EBSR_CAL_N1 :
                       (cal_code == 2'h2) ? EBSR_CAL_N2 :
                       EBSR_CAL_N3; // RULE12
  assign TIMEOUT_ENABLE = sys_r[EBSR_SYS_TMO]; // RULE15
  assign CRC_APPEND = sys_r[EBSR_SYS_CRC]; // RULE13
  assign STATUS_PREPEND = sys_r[EBSR_SYS_STAT]; // RULE14
  // bytes shifted per result: data plus optional status and crc
  assign RESULT_BYTES = EBSR_RES_BYTES + {2'b00, STATUS_PREPEND}
                        + {2'b00, CRC_APPEND}; // RULE13 RULE14

  // assertions
  property p_rd_latency;
    @(posedge MCLK) disable iff (!RST_N)
      RD && hit_sys |=> RDATA == $past(sys_r);
  endproperty
  a_rd_latency: assert property (p_rd_latency) // RULE16
    else $error("read data wrong one cycle after read");
  property p_wr_sys;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_sys ##1 RD && hit_sys |=> RDATA == $past(WDATA, 2);
  endproperty
  a_wr_sys: assert property (p_wr_sys) // RULE11
    else $error("system control did not read back write");
  property p_bias_gen;
    @(posedge MCLK) disable iff (!RST_N)
      BIAS_GEN_EN == (BIAS_TO_COMMON || |BIAS_TO_INPUT);
  endproperty
  a_bias_gen: assert property (p_bias_gen) // RULE6
    else $error("bias generator enable mismatch");
  property p_bias_wr;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_bias |=> BIAS_TO_INPUT == $past(WDATA[5:0])
        && BIAS_LEVEL_SEL == $past(WDATA[7]);
  endproperty
  a_bias_wr: assert property (p_bias_wr) // RULE8
    else $error("bias bits not taken from write");
  property p_com_wr;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_bias |=> BIAS_TO_COMMON == $past(WDATA[6]);
  endproperty
  a_com_wr: assert property (p_com_wr) // RULE7
    else $error("common bias bit not taken");
  property p_route_off;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route && WDATA[7:4] > EBSR_RT_COM |=>
        !SRC2_TO_COMMON && SRC2_TO_INPUT == 12'h000 && !SRC2_TO_REFP;
  endproperty
  a_route_off: assert property (p_route_off) // RULE3
    else $error("second source not disconnected");
  property p_route1;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route && WDATA[3:0] < 4'h6 |=>
        SRC1_TO_INPUT == (12'h001 << $past(WDATA[3:0]));
  endproperty
  a_route1: assert property (p_route1) // RULE4
    else $error("first source routed wrongly");
  property p_cal;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_sys && WDATA[4:3] == 2'h3 |=> CAL_SAMPLES == 5'h10;
  endproperty
  a_cal: assert property (p_cal) // RULE12
    else $error("calibration sample count wrong");
  property p_bytes;
    @(posedge MCLK) disable iff (!RST_N)
      CRC_APPEND && STATUS_PREPEND |-> RESULT_BYTES == 3'h5;
  endproperty
  a_bytes: assert property (p_bytes) // RULE13
    else $error("result length wrong");
  // read port: each register returns its stored value, others zero
  property p_rd_route;
    @(posedge MCLK) disable iff (!RST_N)
      RD && hit_route |=> RDATA == $past(route_r);
  endproperty
  a_rd_route: assert property (p_rd_route) // RULE16
    else $error("route register read wrong");
  property p_rd_bias;
    @(posedge MCLK) disable iff (!RST_N)
      RD && hit_bias |=> RDATA == $past(bias_r);
  endproperty
  a_rd_bias: assert property (p_rd_bias) // RULE16
    else $error("bias register read wrong");
  property p_rd_unmapped;
    @(posedge MCLK) disable iff (!RST_N)
      RD && !hit_route && !hit_bias && !hit_sys |=> RDATA == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) // RULE16
    else $error("unmapped read not zero");
  property p_rd_idle;
    @(posedge MCLK) disable iff (!RST_N)
      !RD |=> RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // RULE16
    else $error("read data outside the read cycle");
  // registers only change on a write strobe
  property p_reg_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !WR |=> $stable(route_r) && $stable(bias_r) && $stable(sys_r);
  endproperty
  a_reg_hold: assert property (p_reg_hold) // RULE16
    else $error("register changed without a write");
  // routing outputs follow the code just written
  property p_route2;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route && WDATA[7:4] < 4'h6 |=>
        SRC2_TO_INPUT == (12'h001 << $past(WDATA[7:4]));
  endproperty
  a_route2: assert property (p_route2) // RULE1
    else $error("second source routed wrongly");
  property p_route_com;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route |=>
        SRC1_TO_COMMON == ($past(WDATA[3:0]) == EBSR_RT_COM)
        && SRC2_TO_COMMON == ($past(WDATA[7:4]) == EBSR_RT_COM);
  endproperty
  a_route_com: assert property (p_route_com) // RULE3
    else $error("common input routing wrong");
  property p_route_ref;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route |=>
        SRC1_TO_REFP == (!WIDE_VARIANT && $past(WDATA[3:0]) == 4'h6)
        && SRC1_TO_REFN == (!WIDE_VARIANT && $past(WDATA[3:0]) == 4'h7);
  endproperty
  a_route_ref: assert property (p_route_ref) // RULE2
    else $error("reference pair routing wrong");
  property p_route_wide;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_route && WDATA[3:0] > 4'h7 && WDATA[3:0] < EBSR_RT_COM |=>
        SRC1_TO_INPUT == (WIDE_VARIANT ? 12'h001 << $past(WDATA[3:0])
        : 12'h000);
  endproperty
  a_route_wide: assert property (p_route_wide) // RULE3
    else $error("upper inputs routed on the wrong variant");
  property p_route_onehot;
    @(posedge MCLK) disable iff (!RST_N)
      $onehot0(SRC1_TO_INPUT) && $onehot0(SRC2_TO_INPUT);
  endproperty
  a_route_onehot: assert property (p_route_onehot) // RULE4
    else $error("a source routed to two inputs");
  // bias enable follows the connect bits that were written
  property p_bias_gen_wr;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_bias |=> BIAS_GEN_EN == ($past(WDATA[6:0]) != 7'h00);
  endproperty
  a_bias_gen_wr: assert property (p_bias_gen_wr) // RULE6
    else $error("bias generator not following connect bits");
  // system control fields follow the value just written
  property p_sys_fields;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_sys |=> MONITOR_SELECT == $past(WDATA[7:5])
        && TIMEOUT_ENABLE == $past(WDATA[2])
        && CRC_APPEND == $past(WDATA[1])
        && STATUS_PREPEND == $past(WDATA[0]);
  endproperty
  a_sys_fields: assert property (p_sys_fields) // RULE11 RULE13 RULE14 RULE15
    else $error("system control fields not taken from write");
  property p_cal_all;
    @(posedge MCLK) disable iff (!RST_N)
      WR && hit_sys |=> CAL_SAMPLES == (($past(WDATA[4:3]) == 2'h0) ? 5'h01
        : ($past(WDATA[4:3]) == 2'h1) ? 5'h04
        : ($past(WDATA[4:3]) == 2'h2) ? 5'h08 : 5'h10);
  endproperty
  a_cal_all: assert property (p_cal_all) // RULE12
    else $error("calibration sample count not per code");
  property p_bytes_plain;
    @(posedge MCLK) disable iff (!RST_N)
      !CRC_APPEND && !STATUS_PREPEND |-> RESULT_BYTES == 3'h3;
  endproperty
  a_bytes_plain: assert property (p_bytes_plain) // RULE14
    else $error("plain result length wrong");
  c_wr_rd: cover property (@(posedge MCLK) WR && hit_route ##1 RD);
  c_bias: cover property (@(posedge MCLK) BIAS_GEN_EN && BIAS_LEVEL_SEL);
  c_crc: cover property (@(posedge MCLK) CRC_APPEND && TIMEOUT_ENABLE);
  c_ref: cover property (@(posedge MCLK) SRC1_TO_REFP || SRC2_TO_REFN);
  c_unmapped: cover property (@(posedge MCLK) RD && !hit_route && !hit_bias
    && !hit_sys);

endmodule
`default_nettype wire

/* File: bench/ebsr_regs_tb_top.sv */
// self-checking bench for the excitation, bias and system control slice
`default_nettype none
module ebsr_regs_tb_top
  import ebsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [11:0] s1_in, s2_in;
  logic s1_p, s1_n, s1_c, s2_p, s2_n, s2_c, b_en, b_lvl, b_com;
  logic [5:0] b_in;
  logic [11:0] n1_in, n2_in;
  logic n1_p, n1_n, n1_c, n2_p, n2_n, n2_c;
  logic [2:0] mon, rbytes;
  logic [4:0] cal;
  logic tmo, crc, stat;
  int n_mismatch = 0;
  int n_compared = 0;
  int m_route, m_bias, m_sys, seed, i;
  int cal_tab[4] = '{1, 4, 8, 16};
  // free-running 50 MHz clock
  always #10 mclk = ~mclk;
  ebsr_regs i_ebsr_regs (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SRC1_TO_INPUT(s1_in), .SRC1_TO_REFP(s1_p), .SRC1_TO_REFN(s1_n),
    .SRC1_TO_COMMON(s1_c), .SRC2_TO_INPUT(s2_in), .SRC2_TO_REFP(s2_p),
    .SRC2_TO_REFN(s2_n), .SRC2_TO_COMMON(s2_c), .BIAS_GEN_EN(b_en),
    .BIAS_LEVEL_SEL(b_lvl), .BIAS_TO_COMMON(b_com), .BIAS_TO_INPUT(b_in),
    .MONITOR_SELECT(mon), .CAL_SAMPLES(cal), .TIMEOUT_ENABLE(tmo),
    .CRC_APPEND(crc), .STATUS_PREPEND(stat), .RESULT_BYTES(rbytes));
  // six-input variant, only its routing outputs are checked here
  ebsr_regs #(.WIDE_VARIANT(1'b0)) i_ebsr_regs_narrow (.MCLK(mclk),
    .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(), .SRC1_TO_INPUT(n1_in), .SRC1_TO_REFP(n1_p),
    .SRC1_TO_REFN(n1_n), .SRC1_TO_COMMON(n1_c), .SRC2_TO_INPUT(n2_in),
    .SRC2_TO_REFP(n2_p), .SRC2_TO_REFN(n2_n), .SRC2_TO_COMMON(n2_c),
    .BIAS_GEN_EN(), .BIAS_LEVEL_SEL(), .BIAS_TO_COMMON(), .BIAS_TO_INPUT(),
    .MONITOR_SELECT(), .CAL_SAMPLES(), .TIMEOUT_ENABLE(), .CRC_APPEND(),
    .STATUS_PREPEND(), .RESULT_BYTES());
  // compare one value and count it
  task automatic cmp(string what, logic [63:0] exp, logic [63:0] seen);
    n_compared++;
    if (exp !== seen) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // expected routing for one code, w set for the twelve-input variant
  function automatic logic [14:0] route_exp(int c, bit w);
    return {12'((c < (w ? 12 : 6)) ? (1 << c) : 0), 1'(!w && c == 6),
      1'(!w && c == 7), 1'(c == 12)};
  endfunction
  // all control outputs against the model
  task automatic check_outs;
    logic [63:0] e;
    e = {route_exp(m_route / 16, 1'b1), route_exp(m_route % 16, 1'b1),
      1'((m_bias % 128) != 0), 8'(m_bias), 3'(m_sys / 32),
      5'(cal_tab[(m_sys / 8) % 4]), 3'(m_sys % 8),
      3'(3 + (m_sys % 2) + ((m_sys / 2) % 2))};
    cmp("outputs", e, {s2_in, s2_p, s2_n, s2_c, s1_in, s1_p, s1_n, s1_c,
      b_en, b_lvl, b_com, b_in, mon, cal, tmo, crc, stat, rbytes});
    cmp("narrow_route", 64'({route_exp(m_route / 16, 1'b0),
      route_exp(m_route % 16, 1'b0)}), 64'({n2_in, n2_p, n2_n, n2_c,
      n1_in, n1_p, n1_n, n1_c}));
  endtask
  // model read value for an address, zero where unmapped
  function automatic int exp_rd(int a);
    return (a == 7) ? m_route : (a == 8) ? m_bias : (a == 9) ? m_sys : 0;
  endfunction
  // one read cycle, data looked at in the cycle after the strobe
  task automatic rd_chk(int a);
    @(posedge mclk);
    addr <= 8'(a);
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp("rdata", 64'(exp_rd(a)), 64'(rdata));
    check_outs;
  endtask
  // write, then read back at the very next edge
  task automatic acc(int a, int d);
    @(posedge mclk);
    addr <= 8'(a);
    wdata <= 8'(d);
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    if (a == 7) m_route = d;
    if (a == 8) m_bias = d;
    if (a == 9) m_sys = d;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp("rdata", 64'(exp_rd(a)), 64'(rdata));
    check_outs;
    @(posedge mclk);
    #1 cmp("rdata_idle", 64'h0, 64'(rdata));
  endtask
  // reset pulse and model reset values
  task automatic do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    m_route = int'(EBSR_RST_ROUTE);
    m_bias = int'(EBSR_RST_BIAS);
    m_sys = int'(EBSR_RST_SYS);
    for (i = 7; i < 10; i++) rd_chk(i);
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    seed = $urandom(32'h4f77);
    do_reset;
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      acc(7, i * 16 + (15 - i));
    end
    $display("test routing done");
    for (i = 0; i < 8; i++) acc(8, 1 << i);
    for (i = 0; i < 12; i++) acc(8, $urandom % 256);
    $display("test bias done");
    for (i = 0; i < 4; i++) acc(9, i * 8 + 16'h00e3 * (i % 2));
    for (i = 0; i < 12; i++) begin
      acc(9, $urandom % 256);
    end
    $display("test system control done");
    acc(10, $urandom % 256);
    acc(6, $urandom % 256);
    for (i = 7; i < 10; i++) rd_chk(i);
    $display("test unmapped done");
    do_reset;
    $display("test second reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
